// ---- common/ptu_params.svh ----
// Constants for the pattern test unit: byte offsets, field positions and codes.
// Assumes byte-wide configuration access with an 11-bit byte address.
`ifndef PTU_PARAMS_SVH
`define PTU_PARAMS_SVH
`define PTU_A_TXA 11'h006
`define PTU_A_TXP 11'h007
`define PTU_A_TXB 11'h008
`define PTU_A_RXA 11'h00a
`define PTU_A_RXB 11'h00b
`define PTU_A_RXC 11'h00c
`define PTU_A_SER 11'h110
`define PTU_A_LB1 11'h11d
`define PTU_A_LB2 11'h132
`define PTU_A_LB3 11'h137
`define PTU_A_DES 11'h13f
`define PTU_A_LB4 11'h142
`define PTU_A_LB5 11'h144
`define PTU_A_ID 11'h400
`define PTU_A_STP 11'h404
`define PTU_A_CTP 11'h405
`define PTU_A_CHN 11'h410
`define PTU_A_CHI 11'h411
`define PTU_A_DIR 11'h412
`define PTU_A_ACC 11'h500
`define PTU_A_ERR 11'h501
`define PTU_A_BIT 11'h50d
`define PTU_TOT_BYTES 7
`define PTU_RW_NUM 30
`define PTU_RW_LIST {11'h006, 11'h007, 11'h008, 11'h00a, 11'h00b, 11'h00c, \
    11'h110, 11'h11d, 11'h132, 11'h137, 11'h13f, 11'h142, 11'h144, 11'h164, \
    11'h210, 11'h212, 11'h213, 11'h214, 11'h215, 11'h218, 11'h223, 11'h311, \
    11'h312, 11'h313, 11'h315, 11'h318, 11'h31a, 11'h320, 11'h321, 11'h322}
`define PTU_SRC_SQ 5'b00101
`define PTU_SRC_PRBS 5'b00100
`define PTU_POLY7 5'b00001
`define PTU_POLY9 5'b00010
`define PTU_POLY15 5'b00100
`define PTU_POLY23 5'b01000
`define PTU_POLY31 5'b10000
`define PTU_SER64 3'b011
`define PTU_SER10 3'b100
`define PTU_DES10 4'b0001
`define PTU_DES64 4'b1110
`define PTU_LB_PRE 6'b100101
`define PTU_LB_POST 6'b001010
`define PTU_SQ_N1 4'b0001
`define PTU_SQ_N4 4'b0100
`define PTU_SQ_N6 4'b1000
`define PTU_SQ_N8 4'b0110
`define PTU_B_SQCLK 7
`define PTU_B_PRBSCLK 6
`define PTU_B_W9 3
`define PTU_B_CHKCLK 7
`define PTU_B_ACC_EN 0
`define PTU_B_ACC_RST 1
`define PTU_B_ACC_SNAP 2
`define PTU_MASK_BASE 11'h080
`define PTU_W_NARROW 7'd10
`define PTU_W_WIDE 7'd64
`endif

// ---- common/ptu_pkg.sv ----
// Types shared by the pattern test unit.
// Assumes the constants header is included by every user of these types.
package ptu_pkg;
    // One configuration access; write and read are single-cycle strobes.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [10:0] addr;
        logic [7:0] wdata;
    } ptu_cfg_req_s;
    typedef enum logic [1:0] {PTU_LB_OFF, PTU_LB_PRE_CDR, PTU_LB_POST_CDR, PTU_LB_UNDEF} ptu_lpbk_e;
endpackage

// ---- verilog/ptu_top.sv ----
// Pattern test unit: square-wave and PRBS source, PRBS checker, soft accumulators.
// Assumes received words arrive on core_clk_i from the deserializer side, one per valid.
//
// Overview of operation
// - Source select {0x008[6:5],0x006[2:0]}: 00101 square wave, 00100 PRBS.
// - Bit 0x006[7] runs or stops the square-wave source.
// - Run-length code 0001/0100/1000/0110 gives n of 1/4/6/8 identical bits.
// - Generator polynomial one-hot {0x008[4],0x007[7:4]}; zero disables PRBS.
// - PRBS9 width bit: one gives 10-bit words, zero leaves the width to the serializer and deserializer codes.
// - Generator and checker each stop entirely while their enable bit is zero.
// - Serializer width code 011 gives 64 bits, 100 gives 10 bits.
// - Checker ignores the first 128, 256, 512 or 1024 errors.
// - Checker polynomial one-hot {0x00C[0],0x00B[7:4]}; zero disables checking.
// - Deserializer width code 0001 gives 10 bits, 1110 gives 64 bits.
// - Accumulator byte: bit0 counts, bit1 held resets, bit2 write captures snapshot.
// - Done flag reads one after four consecutive good PRBS words, until an error or a checker stop.
// - Error total is 50 bits, little-endian from 0x501.
// - Bit total is 50 bits, little-endian from 0x50D.
// - Six-bit loopback code: zero off, 100101 pre-CDR, 001010 post-CDR.
// - Read-only identifier, channel total and channel index bytes.
`include "ptu_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ptu_top
    import ptu_pkg::*;
#(
    parameter logic [31:0] INSTANCE_ID = 32'h0000_0001, // Arbitrary value.
    parameter logic [7:0] CHANNEL_TOTAL = 8'h01,
    parameter logic [7:0] CHANNEL_INDEX = 8'h00,
    parameter logic [1:0] DIRECTION_CODE = 2'b11,
    parameter logic STATUS_PRESENT = 1'b1,
    parameter logic CONTROL_PRESENT = 1'b1,
    parameter int TOT_W = 50,
    parameter logic [3:0] DONE_WORDS = 4'h4
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire ptu_cfg_req_s cfg_req_i,
    output logic [7:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic [63:0] rx_word_i,
    input wire logic rx_valid_i,
    output logic [63:0] tx_word_o,
    output logic tx_valid_o,
    output logic [2:0] ser_mode_o,
    output logic [3:0] deser_mode_o,
    output ptu_lpbk_e lpbk_mode_o,
    output logic prbs_done_o
);
    localparam logic [11*`PTU_RW_NUM-1:0] RW_LIST = `PTU_RW_LIST;

    logic [7:0] rw_r [`PTU_RW_NUM];
    logic [2:0] acc_ctl_r;
    logic [30:0] lfsr_r, lfsr_nxt, chk_hist_r, chk_hist_nxt;
    logic sq_lvl_r, sq_lvl_nxt;
    logic [3:0] sq_cnt_r, sq_cnt_nxt;
    logic [63:0] sq_word, prbs_word;
    logic [6:0] chk_errs;
    logic [10:0] mask_cnt_r, mask_thr;
    logic [3:0] good_run_r;
    logic [TOT_W-1:0] err_tot_r, bit_tot_r, err_snap_r, bit_snap_r;
    logic [7:0] rd_nxt;

    // Byte held by the writable slot at a given offset, zero when none.
    function automatic logic [7:0] rw_byte(input logic [10:0] a);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < `PTU_RW_NUM; i++) begin
            if (RW_LIST[11*i +: 11] == a) begin
                v = rw_r[i];
            end
        end
        return v;
    endfunction

    // Feedback tap pair (zero-based) of each one-hot polynomial code.
    function automatic logic [9:0] taps(input logic [4:0] code);
        case (code)
            `PTU_POLY7: taps = {5'd6, 5'd5};
            `PTU_POLY9: taps = {5'd8, 5'd4};
            `PTU_POLY15: taps = {5'd14, 5'd13};
            `PTU_POLY23: taps = {5'd22, 5'd17};
            `PTU_POLY31: taps = {5'd30, 5'd27};
            default: taps = 10'h000;
        endcase
    endfunction

    function automatic logic one_hot(input logic [4:0] code);
        return taps(code) != 10'h000;
    endfunction

    // Field views over the stored bytes.
    logic [7:0] txa, txb, rxa, rxb, rxc;
    logic [4:0] src_sel, gen_poly, chk_poly;
    logic [5:0] lb_code;
    logic [3:0] sq_n;
    logic sq_on, prbs_on, chk_on, gen_narrow, chk_narrow;
    logic [6:0] gen_w, chk_w;
    // A function result cannot be part-selected, so each byte gets its own net.
    logic [7:0] txp, ser_b, des_b, lb1, lb2, lb3, lb4, lb5;
    assign txp = rw_byte(`PTU_A_TXP);
    assign ser_b = rw_byte(`PTU_A_SER);
    assign des_b = rw_byte(`PTU_A_DES);
    assign lb1 = rw_byte(`PTU_A_LB1);
    assign lb2 = rw_byte(`PTU_A_LB2);
    assign lb3 = rw_byte(`PTU_A_LB3);
    assign lb4 = rw_byte(`PTU_A_LB4);
    assign lb5 = rw_byte(`PTU_A_LB5);
    assign txa = rw_byte(`PTU_A_TXA);
    assign txb = rw_byte(`PTU_A_TXB);
    assign rxa = rw_byte(`PTU_A_RXA);
    assign rxb = rw_byte(`PTU_A_RXB);
    assign rxc = rw_byte(`PTU_A_RXC);
    assign src_sel = {txb[6:5], txa[2:0]};
    assign gen_poly = {txb[4], txp[7:4]};
    assign chk_poly = {rxc[0], rxb[7:4]};
    assign lb_code = {lb1[0], lb2[5:4], lb3[7], lb5[1], lb4[4]};
    assign sq_on = (src_sel == `PTU_SRC_SQ) && txa[`PTU_B_SQCLK];
    assign prbs_on = (src_sel == `PTU_SRC_PRBS) && txa[`PTU_B_PRBSCLK]
                     && one_hot(gen_poly);
    assign chk_on = rxa[`PTU_B_CHKCLK] && one_hot(chk_poly);
    // Narrow words come from the serializer or deserializer width code or the PRBS9 width bit.
    assign gen_narrow = (ser_b[2:0] == `PTU_SER10)
                        || (src_sel == `PTU_SRC_PRBS && gen_poly == `PTU_POLY9
                            && txa[`PTU_B_W9]);
    assign chk_narrow = (des_b[3:0] == `PTU_DES10)
                        || (chk_poly == `PTU_POLY9 && rxc[`PTU_B_W9]);
    assign gen_w = gen_narrow ? `PTU_W_NARROW : `PTU_W_WIDE;
    assign chk_w = chk_narrow ? `PTU_W_NARROW : `PTU_W_WIDE;
    assign mask_thr = `PTU_MASK_BASE << rxb[3:2];

    // Square-wave run length; an undefined code falls back to single-bit runs.
    always_comb begin
        case (txb[3:0])
            `PTU_SQ_N4: sq_n = 4'd4;
            `PTU_SQ_N6: sq_n = 4'd6;
            `PTU_SQ_N8: sq_n = 4'd8;
            default: sq_n = 4'd1;
        endcase
    end

    // One writable byte per slot; every slot has its own offset in the list.
    for (genvar g = 0; g < `PTU_RW_NUM; g++) begin : g_rw
        always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                rw_r[g] <= 8'h00;
            end else if (cfg_req_i.wr && cfg_req_i.addr == RW_LIST[11*g +: 11]) begin
                rw_r[g] <= cfg_req_i.wdata;
            end
        end
    end

    // Accumulator control bits; the snapshot bit reads back as last written.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_ctl_r <= 3'h0;
        end else if (cfg_req_i.wr && cfg_req_i.addr == `PTU_A_ACC) begin
            acc_ctl_r <= cfg_req_i.wdata[2:0];
        end
    end

    // Pattern sources advance bit by bit so that any word width keeps the sequence.
    always_comb begin
        logic [9:0] tp;
        lfsr_nxt = lfsr_r;
        sq_lvl_nxt = sq_lvl_r;
        sq_cnt_nxt = sq_cnt_r;
        sq_word = 64'h0;
        prbs_word = 64'h0;
        tp = taps(gen_poly);
        for (int i = 0; i < 64; i++) begin
            if (7'(i) < gen_w) begin
                sq_word[i] = sq_lvl_nxt;
                if (sq_cnt_nxt == sq_n - 4'd1) begin
                    sq_cnt_nxt = 4'd0;
                    sq_lvl_nxt = ~sq_lvl_nxt;
                end else begin
                    sq_cnt_nxt = sq_cnt_nxt + 4'd1;
                end
                prbs_word[i] = lfsr_nxt[tp[9:5]] ^ lfsr_nxt[tp[4:0]];
                lfsr_nxt = {lfsr_nxt[29:0], prbs_word[i]};
            end
        end
    end

    // Each source holds its state while it is not clocked.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sq_lvl_r <= 1'b0;
            sq_cnt_r <= 4'd0;
        end else if (sq_on) begin
            sq_lvl_r <= sq_lvl_nxt;
            sq_cnt_r <= sq_cnt_nxt;
        end
    end

    // All-ones seed keeps the register out of the stuck all-zero state.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lfsr_r <= '1;
        end else if (prbs_on) begin
            lfsr_r <= lfsr_nxt;
        end
    end

    // Serializer word; bits above the selected width stay zero.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_word_o <= 64'h0;
            tx_valid_o <= 1'b0;
        end else begin
            tx_valid_o <= sq_on || prbs_on;
            tx_word_o <= sq_on ? sq_word : (prbs_on ? prbs_word : 64'h0);
        end
    end

    // Self-synchronising check: each bit is predicted from the received history.
    always_comb begin
        logic [9:0] tp;
        chk_hist_nxt = chk_hist_r;
        chk_errs = 7'd0;
        tp = taps(chk_poly);
        for (int i = 0; i < 64; i++) begin
            if (7'(i) < chk_w) begin
                if (rx_word_i[i] != (chk_hist_nxt[tp[9:5]] ^ chk_hist_nxt[tp[4:0]])) begin
                    chk_errs = chk_errs + 7'd1;
                end
                chk_hist_nxt = {chk_hist_nxt[29:0], rx_word_i[i]};
            end
        end
    end

    logic rx_take;
    assign rx_take = rx_valid_i && chk_on;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chk_hist_r <= '0;
        end else if (rx_take) begin
            chk_hist_r <= chk_hist_nxt;
        end
    end

    // Initial-error mask; restarts when the checker stops or the totals reset.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_cnt_r <= 11'd0;
        end else if (!chk_on || acc_ctl_r[`PTU_B_ACC_RST]) begin
            mask_cnt_r <= 11'd0;
        end else if (rx_take && mask_cnt_r < mask_thr) begin
            if ({1'b0, mask_cnt_r} + {5'h0, chk_errs} >= {1'b0, mask_thr}) begin
                mask_cnt_r <= mask_thr;
            end else begin
                mask_cnt_r <= mask_cnt_r + {4'h0, chk_errs};
            end
        end
    end

    // Done needs a run of error-free words; any error or a stop clears it.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            good_run_r <= 4'd0;
        end else if (!chk_on || (rx_take && chk_errs != 7'd0)) begin
            good_run_r <= 4'd0;
        end else if (rx_take && good_run_r < DONE_WORDS) begin
            good_run_r <= good_run_r + 4'd1;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prbs_done_o <= 1'b0;
        end else begin
            prbs_done_o <= chk_on && good_run_r >= DONE_WORDS;
        end
    end

    // Running totals; errors inside the mask window are not counted.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_tot_r <= '0;
            bit_tot_r <= '0;
        end else if (acc_ctl_r[`PTU_B_ACC_RST]) begin
            err_tot_r <= '0;
            bit_tot_r <= '0;
        end else if (rx_take && acc_ctl_r[`PTU_B_ACC_EN]) begin
            bit_tot_r <= bit_tot_r + TOT_W'(chk_w);
            if (mask_cnt_r >= mask_thr) begin
                err_tot_r <= err_tot_r + TOT_W'(chk_errs);
            end
        end
    end

    // Snapshot on a write of one, so multi-byte reads stay coherent.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_snap_r <= '0;
            bit_snap_r <= '0;
        end else if (cfg_req_i.wr && cfg_req_i.addr == `PTU_A_ACC
                     && cfg_req_i.wdata[`PTU_B_ACC_SNAP]) begin
            err_snap_r <= err_tot_r;
            bit_snap_r <= bit_tot_r;
        end
    end

    // Registered datapath modes: raw serializer and deserializer codes, decoded loopback.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ser_mode_o <= 3'h0;
            deser_mode_o <= 4'h0;
            lpbk_mode_o <= PTU_LB_OFF;
        end else begin
            ser_mode_o <= ser_b[2:0];
            deser_mode_o <= des_b[3:0];
            case (lb_code)
                6'h00: lpbk_mode_o <= PTU_LB_OFF;
                `PTU_LB_PRE: lpbk_mode_o <= PTU_LB_PRE_CDR;
                `PTU_LB_POST: lpbk_mode_o <= PTU_LB_POST_CDR;
                default: lpbk_mode_o <= PTU_LB_UNDEF;
            endcase
        end
    end

    // Read decode; unmapped offsets read zero.
    always_comb begin
        logic [63:0] es, bs;
        es = 64'(err_snap_r);
        bs = 64'(bit_snap_r);
        rd_nxt = rw_byte(cfg_req_i.addr);
        for (int i = 0; i < 4; i++) begin
            if (cfg_req_i.addr == `PTU_A_ID + 11'(i)) begin
                rd_nxt = INSTANCE_ID[8*i +: 8];
            end
        end
        for (int i = 0; i < `PTU_TOT_BYTES; i++) begin
            if (cfg_req_i.addr == `PTU_A_ERR + 11'(i)) begin
                rd_nxt = es[8*i +: 8];
            end
            if (cfg_req_i.addr == `PTU_A_BIT + 11'(i)) begin
                rd_nxt = bs[8*i +: 8];
            end
        end
        case (cfg_req_i.addr)
            `PTU_A_STP: rd_nxt = {7'h0, STATUS_PRESENT};
            `PTU_A_CTP: rd_nxt = {7'h0, CONTROL_PRESENT};
            `PTU_A_CHN: rd_nxt = CHANNEL_TOTAL;
            `PTU_A_CHI: rd_nxt = CHANNEL_INDEX;
            `PTU_A_DIR: rd_nxt = {6'h0, DIRECTION_CODE};
            `PTU_A_ACC: rd_nxt = {4'h0, prbs_done_o, acc_ctl_r};
            default: rd_nxt = rd_nxt;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_rdata_o <= 8'h00;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_req_i.rd;
            cfg_rdata_o <= cfg_req_i.rd ? rd_nxt : 8'h00;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    src_square_a: assert property (sq_on |=> tx_valid_o && tx_word_o == $past(sq_word))
        else $error("square source not routed");
    sq_stop_a: assert property (!sq_on && !prbs_on |=> !tx_valid_o && $stable(sq_lvl_r))
        else $error("stopped source still active");
    run_one_a: assert property (sq_on && sq_n == 4'd1 |=> tx_word_o[1] != tx_word_o[0])
        else $error("single-bit runs do not alternate");
    poly_off_a: assert property ((src_sel == `PTU_SRC_PRBS) && !one_hot(gen_poly)
        |=> !tx_valid_o)
        else $error("PRBS sent with no polynomial");
    narrow_word_a: assert property (tx_valid_o && $past(gen_narrow) |-> tx_word_o[63:10] == 54'h0)
        else $error("narrow word carries upper bits");
    chk_hold_a: assert property (!chk_on && !acc_ctl_r[`PTU_B_ACC_RST]
        |=> $stable(chk_hist_r) && $stable(err_tot_r))
        else $error("stopped checker changed state");
    mask_window_a: assert property (mask_cnt_r < mask_thr && !acc_ctl_r[`PTU_B_ACC_RST]
        |=> $stable(err_tot_r))
        else $error("error counted inside mask window");
    acc_reset_a: assert property (acc_ctl_r[`PTU_B_ACC_RST] |=> err_tot_r == '0 && bit_tot_r == '0)
        else $error("totals not cleared");
    snap_take_a: assert property (cfg_req_i.wr && cfg_req_i.addr == `PTU_A_ACC
        && cfg_req_i.wdata[`PTU_B_ACC_SNAP] |=> err_snap_r == $past(err_tot_r))
        else $error("snapshot missed error total");
    done_flag_a: assert property (rx_take && chk_errs != 7'd0 |=> ##1 !prbs_done_o)
        else $error("done stays after error");
    lpbk_pre_a: assert property (lb_code == `PTU_LB_PRE |=> lpbk_mode_o == PTU_LB_PRE_CDR)
        else $error("pre-CDR loopback not selected");
    rd_total_a: assert property (cfg_req_i.rd && cfg_req_i.addr == `PTU_A_CHN
        |=> cfg_rvalid_o && cfg_rdata_o == CHANNEL_TOTAL)
        else $error("channel total misread");

    prbs_sent_c: cover property (prbs_on ##1 tx_valid_o);
    done_seen_c: cover property (!prbs_done_o ##1 prbs_done_o);
    err_count_c: cover property (rx_take && mask_cnt_r >= mask_thr && chk_errs != 7'd0);
    snap_read_c: cover property (cfg_req_i.rd && cfg_req_i.addr == `PTU_A_ERR);
endmodule
`default_nettype wire

// ---- sim/ptu_link_model.sv ----
// Far-end model: a serial loopback that returns each serializer word to the receiver.
// Assumes one clock domain; the bench gates the traffic and orders corruption.
`timescale 1ns/1ps
`default_nettype none
module ptu_link_model (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic pass_i,
    input wire logic corrupt_i,
    input wire logic [63:0] noise_i,
    input wire logic [63:0] tx_word_i,
    input wire logic tx_valid_i,
    output logic [63:0] rx_word_o,
    output logic rx_valid_o
);
    // Idle cycles show the inverted word, so stale data never passes for a good word.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_word_o <= 64'h0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= tx_valid_i & pass_i;
            if (tx_valid_i & pass_i) begin
                rx_word_o <= corrupt_i ? noise_i : tx_word_i;
            end else begin
                rx_word_o <= ~rx_word_o;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the pattern test unit with a loopback far end.
// Assumes the constants header and the package are compiled first.
`include "ptu_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import ptu_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    ptu_cfg_req_s req = '0;
    logic [7:0] rdata;
    logic rvalid, tx_valid, rx_valid, done;
    logic pass = 1'b0;
    logic corrupt = 1'b0;
    logic [63:0] rx_word, tx_word;
    logic [63:0] noise = 64'h0;
    logic [2:0] ser_mode;
    logic [3:0] deser_mode;
    ptu_lpbk_e lpbk;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'he1db;
    int nw = 0;
    int nk = 0;
    logic [7:0] v;
    logic [49:0] et, bt, b2;
    logic [`PTU_RW_NUM*11-1:0] rwl = `PTU_RW_LIST;
    logic [18:0] sw [14] = '{19'h21009, 19'h21400, 19'h31207, 19'h31302, 19'h31100, 19'h31802,
        19'h32002, 19'h32118, 19'h32241, 19'h21347, 19'h21200, 19'h21500, 19'h21840, 19'h31500};
    logic [54:0] lba = {`PTU_A_LB1, `PTU_A_LB2, `PTU_A_LB3, `PTU_A_LB5, `PTU_A_LB4};
    logic [39:0] lbv [4] = '{40'h0100800010, 40'h0010000200, 40'h0100000000, 40'h0};
    ptu_lpbk_e lbe [4] = '{PTU_LB_PRE_CDR, PTU_LB_POST_CDR, PTU_LB_UNDEF, PTU_LB_OFF};
    logic [3:0] sqc [4] = '{`PTU_SQ_N1, `PTU_SQ_N4, `PTU_SQ_N6, `PTU_SQ_N8};
    int sqn [4] = '{1, 4, 6, 8};
    logic [4:0] pl [5] = '{`PTU_POLY7, `PTU_POLY9, `PTU_POLY15, `PTU_POLY23, `PTU_POLY31};

    ptu_top dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .cfg_req_i(req),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .rx_word_i(rx_word), .rx_valid_i(rx_valid),
        .tx_word_o(tx_word), .tx_valid_o(tx_valid), .ser_mode_o(ser_mode),
        .deser_mode_o(deser_mode), .lpbk_mode_o(lpbk), .prbs_done_o(done));
    ptu_link_model link (.clk_i(core_clk), .reset_n_i(reset_n), .pass_i(pass),
        .corrupt_i(corrupt), .noise_i(noise), .tx_word_i(tx_word), .tx_valid_i(tx_valid),
        .rx_word_o(rx_word), .rx_valid_o(rx_valid));

    // Clock, noise for corrupted words, and a count of words handed to the checker.
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        noise <= {$random(seed), $random(seed)};
        if (rx_valid === 1'b1) nw++;
    end

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h0};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_tot(input logic [10:0] b, output logic [49:0] t);
        logic [55:0] acc;
        for (int i = 0; i < `PTU_TOT_BYTES; i++) begin
            rd(b + 11'(i), v);
            acc[i*8 +: 8] = v;
        end
        t = acc[49:0];
    endtask
    // Write the accumulator byte c to take a snapshot, then read both totals.
    task automatic snap(input logic [7:0] c);
        wr(`PTU_A_ACC, c);
        rd_tot(`PTU_A_ERR, et);
        rd_tot(`PTU_A_BIT, bt);
    endtask
    task automatic run(input int k, input logic c);
        @(posedge core_clk);
        pass <= 1'b1;
        corrupt <= c;
        repeat (k) @(posedge core_clk);
        pass <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    // The checker is disabled first so its mask and done run restart cleanly.
    task automatic setup(input logic [4:0] gp, cp, input logic w9, input logic [1:0] mk);
        wr(`PTU_A_RXA, 8'h00);
        wr(`PTU_A_TXP, {gp[3:0], 4'h0});
        wr(`PTU_A_TXB, {3'b000, gp[4], 4'h0});
        wr(`PTU_A_TXA, {4'h4, w9, 3'b100});
        wr(`PTU_A_RXB, {cp[3:0], mk, 2'b00});
        wr(`PTU_A_RXC, {4'h0, w9, 2'b00, cp[4]});
        wr(`PTU_A_SER, w9 ? 8'h04 : 8'h03);
        wr(`PTU_A_DES, w9 ? 8'h01 : 8'h0e);
        wr(`PTU_A_RXA, 8'h80);
        wr(`PTU_A_ACC, 8'h03);
        wr(`PTU_A_ACC, 8'h01);
        nw = 0;
    endtask
    // Square wave: every inner run is n long, edge runs no longer.
    function automatic logic sq_ok(input logic [63:0] w, input int n);
        int len = 1;
        logic first = 1'b1;
        sq_ok = 1'b1;
        for (int i = 1; i < 64; i++) begin
            if (w[i] === w[i-1]) begin
                len++;
            end else begin
                if ((!first && len != n) || len > n) sq_ok = 1'b0;
                first = 1'b0;
                len = 1;
            end
        end
        if (len > n) sq_ok = 1'b0;
    endfunction
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the thousand or so cycles the sequence needs.
    initial begin
        #500_000;
        err_total++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(`PTU_A_CHN, v); `CHK("chn", 8'h01, v)
        rd(`PTU_A_CHI, v); `CHK("chi", 8'h00, v)
        rd(`PTU_A_ID, v); `CHK("id0", 8'h01, v)
        wr(`PTU_A_DIR, 8'h00);
        rd(`PTU_A_DIR, v); `CHK("dir", 8'h03, v)
        rd(`PTU_A_STP, v); `CHK("stp", 8'h01, v)
        rd(`PTU_A_CTP, v); `CHK("ctp", 8'h01, v)
        rd(11'h7ff, v); `CHK("unmapped", 8'h00, v)
        for (int i = 0; i < `PTU_RW_NUM; i++) begin
            b2[7:0] = 8'($random(seed));
            wr(rwl[i*11 +: 11], b2[7:0]);
            rd(rwl[i*11 +: 11], v); `CHK("rw", b2[7:0], v)
        end
        for (int i = 0; i < 14; i++) wr(sw[i][18:8], sw[i][7:0]);
        for (int j = 0; j < 4; j++) begin
            for (int k = 0; k < 5; k++) wr(lba[k*11 +: 11], lbv[j][k*8 +: 8]);
            repeat (2) @(posedge core_clk);
            #1 `CHK("lpbk", lbe[j], lpbk)
        end
        wr(`PTU_A_SER, 8'h04);
        wr(`PTU_A_DES, 8'h01);
        repeat (2) @(posedge core_clk);
        #1 `CHK("ser", `PTU_SER10, ser_mode)
        `CHK("des", `PTU_DES10, deser_mode)
        wr(`PTU_A_SER, 8'h03);
        for (int j = 0; j < 4; j++) begin
            wr(`PTU_A_TXB, {4'h0, sqc[j]});
            wr(`PTU_A_TXA, 8'h85);
            repeat (3) @(posedge core_clk);
            #1 `CHK("sq", 1'b1, sq_ok(tx_word, sqn[j]))
            `CHK("sqv", 1'b1, tx_valid)
        end
        `CHK("ser64", `PTU_SER64, ser_mode)
        wr(`PTU_A_TXA, 8'h05);
        repeat (2) @(posedge core_clk);
        #1 `CHK("sqoff", 1'b0, tx_valid)
        for (int j = 0; j < 5; j++) begin
            setup(pl[j], pl[j], 1'b0, 2'b00);
            run(20, 1'b0);
            `CHK("done", 1'b1, done)
            snap(8'h05);
            `CHK("bits", 50'(64 * nw), bt)
            `CHK("errs", 50'h0, et)
        end
        run(6, 1'b0);
        rd_tot(`PTU_A_BIT, b2);
        `CHK("hold", bt, b2)
        nk = nw;
        wr(`PTU_A_ACC, 8'h00);
        run(6, 1'b0);
        snap(8'h04);
        `CHK("cnt_off", 50'(64 * nk), bt)
        wr(`PTU_A_ACC, 8'h02);
        snap(8'h04);
        `CHK("clear", 50'h0, bt)
        setup(`PTU_POLY7, `PTU_POLY15, 1'b0, 2'b00);
        run(20, 1'b0);
        `CHK("mismatch", 1'b0, done)
        setup(`PTU_POLY9, `PTU_POLY9, 1'b1, 2'b00);
        run(20, 1'b0);
        `CHK("narrow", 54'h0, tx_word[63:10])
        snap(8'h05);
        `CHK("bits10", 50'(10 * nw), bt)
        for (int j = 0; j < 2; j++) begin
            setup(`PTU_POLY7, `PTU_POLY7, 1'b0, j ? 2'b11 : 2'b00);
            run(12, 1'b0);
            wr(`PTU_A_ACC, 8'h03);
            wr(`PTU_A_ACC, 8'h01);
            run(10, 1'b1);
            `CHK("drop", 1'b0, done)
            snap(8'h05);
            `CHK("mask", 1'(j), et == 50'h0)
        end
        reset_n <= 1'b0;
        @(posedge core_clk);
        reset_n <= 1'b1;
        rd(`PTU_A_TXA, v); `CHK("rst_cfg", 8'h00, v)
        `CHK("rst_done", 1'b0, done)
        test_done();
    end
endmodule
`default_nettype wire
